// ==== jie_pkg.sv ====
// jie_pkg: constants and carrier types for the jump and increment executor
// assumes a 12-bit instruction word and an 8-bit data path
package jie_pkg;

	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int JIE_IW      = 12;
	localparam int JIE_DW      = 8;
	localparam int JIE_AW      = 5;
	localparam int JIE_PCW     = 11;
	localparam int JIE_IMMW    = 9;

	// ----------------------------------------------------------------
	// opcode patterns and field positions
	// ----------------------------------------------------------------
	localparam logic [2:0] JIE_OP_JUMP      = 3'h5;  // 101k kkkk kkkk
	localparam logic [5:0] JIE_OP_INC       = 6'h0a; // 0010 10df ffff
	localparam logic [5:0] JIE_OP_INC_SKIP  = 6'h0f; // 0011 11df ffff
	localparam int         JIE_DEST_BIT     = 5;
	localparam int         JIE_ADDR_LSB     = 0;
	localparam int         JIE_PAGE_LSB     = 5;     // status bits 6:5

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [JIE_DW-1:0]  JIE_DATA_RST = 8'h00;
	localparam logic [JIE_PCW-1:0] JIE_PC_RST   = 11'h000;
	localparam logic [JIE_AW-1:0]  JIE_ADDR_RST = 5'h00;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [0:0] {
		JIE_EXEC,
		JIE_FLUSH
	} jie_mode_e;

	typedef struct packed {
		logic              we;
		logic [JIE_AW-1:0] addr;
		logic [JIE_DW-1:0] data;
	} jie_file_wr_s;

	typedef struct packed {
		logic               load;
		logic [JIE_PCW-1:0] value;
	} jie_pc_s;

	typedef struct packed {
		logic              w_we;
		logic [JIE_DW-1:0] w_data;
		logic              z_we;
		logic              z_val;
	} jie_core_wr_s;

endpackage

// ==== jie_incr.sv ====
// jie_incr: eight-bit wrap-around incrementer with zero detect
// assumes a purely combinational use inside the executor
`timescale 1ns/1ps

module jie_incr
	import jie_pkg::*;
(
	// operand
	input  wire logic [JIE_DW-1:0] operand_in,
	// result
	output logic      [JIE_DW-1:0] sum_out,
	output logic                   zero_out
);

	// carry out of bit 7 is dropped on purpose
	assign sum_out  = JIE_DW'(operand_in + 8'h01);
	assign zero_out = (sum_out == JIE_DATA_RST);

endmodule

// ==== jie_exec.sv ====
// jie_exec: decode and execute of jump, increment, increment-skip
// assumes the file register read is combinational from the address,
// and that instructions arrive one per cycle from the fetch stage
// limitation: a registered file read would need a stall that this block
// does not have; the read must settle inside the issue cycle
// trade-off: the flush costs a cycle but keeps decode out of fetch
`timescale 1ns/1ps

module jie_exec
	import jie_pkg::*;
(
	// clock and control
	input  wire logic               clock_in,
	input  wire logic               rst_in,
	input  wire logic               ce_in,
	// instruction from fetch
	input  wire logic               instr_valid_in,
	input  wire logic [JIE_IW-1:0]  instr_in,
	// core state
	input  wire logic [JIE_DW-1:0]  status_in,
	// file register read port
	output logic      [JIE_AW-1:0]  file_raddr_out,
	input  wire logic [JIE_DW-1:0]  file_rdata_in,
	// file register write port
	output logic                    file_we_out,
	output logic      [JIE_AW-1:0]  file_waddr_out,
	output logic      [JIE_DW-1:0]  file_wdata_out,
	// accumulator and zero flag writes
	output logic                    w_we_out,
	output logic      [JIE_DW-1:0]  w_data_out,
	output logic                    z_we_out,
	output logic                    z_out,
	// program counter load
	output logic                    pc_load_out,
	output logic      [JIE_PCW-1:0] pc_value_out,
	// pipeline control
	output logic                    squash_out,
	output logic                    busy_out
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		jie_mode_e    mode;
		jie_file_wr_s file_wr;
		jie_core_wr_s core_wr;
		jie_pc_s      pc;
	} jie_state_s;

	// strobes live in the state so every output except file_raddr_out comes from a flip-flop
	jie_state_s state_q;
	jie_state_s state_d;

	// ----------------------------------------------------------------
	// decode helpers
	// ----------------------------------------------------------------
	function automatic logic jie_is_jump(input logic [JIE_IW-1:0] w);
		jie_is_jump = (w[JIE_IW-1 -: 3] == JIE_OP_JUMP);
	endfunction

	function automatic logic jie_is_op6(input logic [JIE_IW-1:0] w,
	                                    input logic [5:0]        op);
		jie_is_op6 = (w[JIE_IW-1 -: 6] == op);
	endfunction

	// page bits sit above the immediate; old counter bits are never kept
	function automatic logic [JIE_PCW-1:0] jie_jump_target(
		input logic [JIE_IW-1:0] w,
		input logic [JIE_DW-1:0] st);
		jie_jump_target = {st[JIE_PAGE_LSB +: 2],
		                   w[JIE_IMMW-1:0]};
	endfunction

	// ----------------------------------------------------------------
	// datapath
	// ----------------------------------------------------------------
	logic [JIE_DW-1:0] inc_sum;
	logic              inc_zero;
	logic [JIE_AW-1:0] faddr;
	logic              dest_file;
	logic              take;
	logic              is_jump;
	logic              is_inc;
	logic              is_skip;

	assign faddr     = instr_in[JIE_ADDR_LSB +: JIE_AW];
	assign dest_file = instr_in[JIE_DEST_BIT];
	// a word arriving while the flush runs is the discarded one
	assign take      = ce_in && instr_valid_in
	                   && (state_q.mode == JIE_EXEC);

	// qualified by take, so an idle, frozen or dropped word decodes to none
	assign is_jump   = take && jie_is_jump(instr_in);
	assign is_inc    = take && jie_is_op6(instr_in, JIE_OP_INC);
	assign is_skip   = take && jie_is_op6(instr_in, JIE_OP_INC_SKIP);

	assign file_raddr_out = faddr;

	jie_incr u_incr (
		.operand_in (file_rdata_in),
		.sum_out    (inc_sum),
		.zero_out   (inc_zero)
	);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		state_d = state_q;
		if (ce_in)
		begin
			// write strobes last one enabled cycle only; with the enable low they hold
			state_d.file_wr.we = 1'b0;
			state_d.core_wr.w_we = 1'b0;
			state_d.core_wr.z_we = 1'b0;
			state_d.pc.load = 1'b0;
			case (state_q.mode)
				JIE_EXEC:
				begin
					if (is_jump)
					begin
						state_d.pc.load  = 1'b1;
						state_d.pc.value =
							jie_jump_target(instr_in, status_in);
						// second cycle flushes the prefetch
						state_d.mode = JIE_FLUSH;
					end
					else if (is_inc || is_skip)
					begin
						if (dest_file)
						begin
							state_d.file_wr.we   = 1'b1;
							state_d.file_wr.addr = faddr;
							state_d.file_wr.data = inc_sum;
						end
						else
						begin
							state_d.core_wr.w_we   = 1'b1;
							state_d.core_wr.w_data = inc_sum;
						end
						if (is_inc)
						begin
							state_d.core_wr.z_we  = 1'b1;
							state_d.core_wr.z_val = inc_zero;
						end
						else if (inc_zero)
						begin
							// skip form never touches the flags
							state_d.mode = JIE_FLUSH;
						end
					end
				end
				JIE_FLUSH:
				begin
					// the prefetched word is dropped and acts as a nop
					// with the enable low the flush holds, so it cannot slip in
					state_d.mode = JIE_EXEC;
				end
				default:
				begin
					// an illegal mode falls back to execute
					state_d.mode = JIE_EXEC;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	// reset is not gated by the enable: a core held in reset must leave
	// it idle whatever the enable does
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			state_q.mode           <= JIE_EXEC;
			state_q.file_wr.we     <= 1'b0;
			state_q.file_wr.addr   <= JIE_ADDR_RST;
			state_q.file_wr.data   <= JIE_DATA_RST;
			state_q.core_wr.w_we   <= 1'b0;
			state_q.core_wr.w_data <= JIE_DATA_RST;
			state_q.core_wr.z_we   <= 1'b0;
			state_q.core_wr.z_val  <= 1'b0;
			state_q.pc.load        <= 1'b0;
			state_q.pc.value       <= JIE_PC_RST;
		end
		else
		begin
			state_q <= state_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign file_we_out    = state_q.file_wr.we;
	assign file_waddr_out = state_q.file_wr.addr;
	assign file_wdata_out = state_q.file_wr.data;
	assign w_we_out       = state_q.core_wr.w_we;
	assign w_data_out     = state_q.core_wr.w_data;
	assign z_we_out       = state_q.core_wr.z_we;
	assign z_out          = state_q.core_wr.z_val;
	assign pc_load_out    = state_q.pc.load;
	assign pc_value_out   = state_q.pc.value;
	assign squash_out     = (state_q.mode == JIE_FLUSH);
	// busy mirrors squash so a fetch unit may stall on either
	assign busy_out       = (state_q.mode == JIE_FLUSH);

endmodule

// ==== jie_exec_checker.sv ====
// jie_exec_checker: port-level timing checks for jie_exec
// assumes it is bound onto jie_exec and sees only its ports
`timescale 1ns/1ps

module jie_exec_checker
(
	input wire logic        clock_in,
	input wire logic        rst_in,
	input wire logic        ce_in,
	input wire logic        instr_valid_in,
	input wire logic [11:0] instr_in,
	input wire logic [7:0]  status_in,
	input wire logic [7:0]  file_rdata_in,
	input wire logic        file_we_out,
	input wire logic [7:0]  file_wdata_out,
	input wire logic        w_we_out,
	input wire logic [7:0]  w_data_out,
	input wire logic        z_we_out,
	input wire logic        z_out,
	input wire logic        pc_load_out,
	input wire logic [10:0] pc_value_out,
	input wire logic        squash_out,
	input wire logic        busy_out
);
	logic iss, jmp, inc, skp;
	assign iss = ce_in && instr_valid_in && !squash_out;
	assign jmp = iss && instr_in[11:9] == 3'h5;
	assign inc = iss && instr_in[11:6] == 6'h0a;
	assign skp = iss && instr_in[11:6] == 6'h0f;
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (rst_in);
	// ----
	// properties
	// ----
	property p_pc; jmp |=> pc_load_out && pc_value_out ==
		{$past(status_in[6:5]), $past(instr_in[8:0])}; endproperty
	a_pc: assert property (p_pc)
		else $error("jump target wrong");
	property p_jf; jmp |=> squash_out && !z_we_out && !w_we_out
		&& !file_we_out; endproperty
	a_jf: assert property (p_jf)
		else $error("jump side effect");
	property p_iz; inc |=> z_we_out &&
		z_out == ($past(file_rdata_in) == 8'hff); endproperty
	a_iz: assert property (p_iz)
		else $error("zero flag wrong");
	property p_ds; inc || skp |=> file_we_out == $past(instr_in[5])
		&& w_we_out == !$past(instr_in[5]); endproperty
	a_ds: assert property (p_ds)
		else $error("destination wrong");
	property p_sm; inc || skp |=> $past(file_rdata_in) + 8'h01 ==
		(file_we_out ? file_wdata_out : w_data_out); endproperty
	a_sm: assert property (p_sm)
		else $error("sum wrong");
	property p_sz; skp |=> !z_we_out; endproperty
	a_sz: assert property (p_sz)
		else $error("skip touched zero flag");
	property p_ss; skp |=>
		squash_out == ($past(file_rdata_in) == 8'hff); endproperty
	a_ss: assert property (p_ss)
		else $error("skip squash wrong");
	property p_s1; squash_out && ce_in |=> !squash_out; endproperty
	a_s1: assert property (p_s1)
		else $error("squash too long");
	property p_by; jmp || skp && file_rdata_in == 8'hff |=> busy_out;
		endproperty
	a_by: assert property (p_by)
		else $error("busy missing after jump or skip");
	property p_ce; !ce_in |=> $stable(squash_out) && $stable(pc_load_out)
		&& $stable(pc_value_out) && $stable(file_we_out)
		&& $stable(file_wdata_out) && $stable(w_we_out)
		&& $stable(w_data_out) && $stable(z_we_out)
		&& $stable(z_out); endproperty
	a_ce: assert property (p_ce) // clock enable freeze
		else $error("state moved with enable low");
endmodule

bind jie_exec jie_exec_checker chk (.clock_in(clock_in), .rst_in(rst_in),
	.ce_in(ce_in), .instr_valid_in(instr_valid_in), .instr_in(instr_in),
	.status_in(status_in), .file_rdata_in(file_rdata_in),
	.file_we_out(file_we_out), .file_wdata_out(file_wdata_out),
	.w_we_out(w_we_out), .w_data_out(w_data_out), .z_we_out(z_we_out),
	.z_out(z_out), .pc_load_out(pc_load_out),
	.pc_value_out(pc_value_out), .squash_out(squash_out),
	.busy_out(busy_out));

// ==== jie_exec_tb.sv ====
// jie_exec_tb: random instruction stream against a result scoreboard
// assumes a combinational file read; file contents stay fixed
`timescale 1ns/1ps

module jie_exec_tb;
	logic        clock_in, rst_in, ce_in, vld, pend, d, fwe, wwe, zwe, z;
	logic        pcl, sq, tk;
	logic [11:0] w;
	logic [7:0]  st, s, wd, wdat, k;
	logic [7:0]  mem [32];
	logic [4:0]  ra, wa;
	logic [10:0] pcv;
	logic [37:0] exq [$];
	logic [37:0] obs;
	int          err_total, checks, seed;

	jie_exec dut (.clock_in(clock_in), .rst_in(rst_in), .ce_in(ce_in),
		.instr_valid_in(vld), .instr_in(w), .status_in(st),
		.file_raddr_out(ra), .file_rdata_in(mem[ra]),
		.file_we_out(fwe), .file_waddr_out(wa), .file_wdata_out(wd),
		.w_we_out(wwe), .w_data_out(wdat), .z_we_out(zwe), .z_out(z),
		.pc_load_out(pcl), .pc_value_out(pcv), .squash_out(sq),
		.busy_out());

	// data fields masked by their strobes: held values are not results
	assign obs = {pcl, pcl ? pcv : 11'h0, fwe, fwe ? wa : 5'h0,
		fwe ? wd : 8'h0, wwe, wwe ? wdat : 8'h0, zwe, zwe & z, sq};

	initial
	begin
		clock_in = 0;
		forever #50 clock_in = ~clock_in;
	end

	// ----
	// monitor
	// ----
	always @(posedge clock_in)
	begin
		#1;
		// strobes held through a frozen edge are not new results
		if (ce_in && (pcl | fwe | wwe | zwe) !== 1'b0)
		begin
			checks++;
			if (exq.size() == 0 || obs !== exq[0])
			begin
				err_total++;
				$display("wrong value at %0t: %h vs %h", $time, obs,
					exq.size() ? exq[0] : 38'h0);
			end
			if (exq.size())
				void'(exq.pop_front());
		end
	end

	task end_of_test;
		begin
			$display("checks %0d err_total %0d", checks, err_total);
			if (err_total == 0 && checks > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask

	// ----
	// stimulus
	// ----
	initial
	begin
		seed = 93766;
		err_total = 0;
		checks = 0;
		pend = 0;
		ce_in = 1;
		vld = 0;
		w = 12'h000;
		st = 8'h00;
		rst_in = 1;
		for (int i = 0; i < 32; i++)
			mem[i] = (i % 4 == 0) ? 8'hff : 8'($random(seed));
		repeat (4) @(negedge clock_in);
		for (int i = 0; i < 400; i++)
		begin
			rst_in = (i == 0 || i == 200);
			k = 8'($random(seed));
			w = 12'($random(seed));
			st = 8'($random(seed));
			vld = k[4] | k[5];
			// enable low about one cycle in four freezes the block
			ce_in = (k[7:6] != 2'h0);
			case (k[1:0])
				2'h0: w[11:9] = 3'h5;
				2'h1: w[11:6] = 6'h0a;
				2'h2: w[11:6] = 6'h0f;
				default: w[11:6] = k[2] ? 6'h0b : 6'h0e; // near misses
			endcase
			s = mem[w[4:0]] + 8'h01;
			d = w[5];
			tk = ce_in && vld && !pend && !rst_in;
			if (tk && k[1:0] == 2'h0)
				exq.push_back({1'b1, st[6:5], w[8:0], 25'h0, 1'b1});
			else if (tk && k[1:0] != 2'h3)
				exq.push_back({12'h0, d, d ? w[4:0] : 5'h0, d ? s : 8'h0,
					!d, d ? 8'h0 : s, k[1:0] == 2'h1,
					k[1:0] == 2'h1 && s == 8'h0,
					k[1:0] == 2'h2 && s == 8'h0});
			if (rst_in)
				pend = 0;
			else if (ce_in)
				pend = tk && (k[1:0] == 2'h0 ||
					(k[1:0] == 2'h2 && s == 8'h0));
			@(negedge clock_in);
		end
		vld = 0;
		for (int j = 0; j < 8 && exq.size() > 0; j++)
			@(negedge clock_in);
		if (exq.size() > 0)
			err_total++;
		end_of_test();
	end
endmodule
